// ---- hw/msc_regs.vh ----
// serial command interpreter constants
`ifndef MSC_REGS_VH
`define MSC_REGS_VH

// clock and link timing
`define MSC_CLK_HZ          125000000
`define MSC_BAUD_19200      19200
`define MSC_BIT_CYC         (`MSC_CLK_HZ / `MSC_BAUD_19200)
`define MSC_BAUD_CODE_19200 2'h0

// speed timeouts
`define MSC_TO_A_MS         50
`define MSC_TO_B_MS         500
`define MSC_TO_C_MS         2800
`define MSC_CYC_PER_MS      (`MSC_CLK_HZ / 1000)
`define MSC_TO_A_CYC        (`MSC_TO_A_MS * `MSC_CYC_PER_MS)
`define MSC_TO_B_CYC        (`MSC_TO_B_MS * `MSC_CYC_PER_MS)
`define MSC_TO_C_CYC        (`MSC_TO_C_MS * `MSC_CYC_PER_MS)

// frame fields
`define MSC_ADDR_FLAG       7
`define MSC_DATA_MASK       7'h7F
`define MSC_CAL_PCT         20

// command codes
`define MSC_WR_STORE_SEL    7'h72
`define MSC_RD_STORE_SEL    7'h33
`define MSC_WR_DRIVE_CFG    7'h74
`define MSC_RD_DRIVE_CFG    7'h34
`define MSC_WR_FEAT_CFG     7'h75
`define MSC_RD_FEAT_CFG     7'h35
`define MSC_WR_UNIT_ADDR    7'h7C
`define MSC_WR_CUR_TRIM     7'h7D
`define MSC_RD_FW_VER       7'h3E
`define MSC_RD_HW_VER       7'h3F

// store select fields
`define MSC_SEL_POT_MAX     4
`define MSC_SEL_POT_MIN     3
`define MSC_SEL_TOP_SPEED   2
`define MSC_SEL_RES_COMP    1
`define MSC_SEL_CUR_CAL     0
`define MSC_SEL_MASK        14'h001F

// drive configuration fields
`define MSC_DC_FWD          9
`define MSC_DC_MODE         4
`define MSC_DC_BRAKE        3
`define MSC_DC_TO_HI        2
`define MSC_DC_TO_LO        1
`define MSC_DC_GATE         0
`define MSC_DC_MASK         14'h021F

// feature configuration fields
`define MSC_FC_SUPPLY       8
`define MSC_FC_PIN_OFF      7
`define MSC_FC_PULSE_RES    6
`define MSC_FC_BAUD_HI      2
`define MSC_FC_BAUD_LO      1
`define MSC_FC_MASK         14'h01C6

// reset values
`define MSC_RST_STORE_SEL   14'h0000
`define MSC_RST_DRIVE_CFG   14'h0000
`define MSC_RST_FEAT_CFG    14'h0000
`define MSC_RST_UNIT_ADDR   7'h00
`define MSC_RST_CUR_TRIM    14'h0000

`endif

// ---- hw/msc_top.v ----
// motor controller serial command interpreter
//
// How it works
// - store-select write marks items, starts flash store
// - restore stored values at restart, lock them
// - during store halt pwm, refuse other frames
// - store-select bits pick pot max/min, top, comp, cal
// - drive config codes 74/34, bit 9 forward
// - mode bits serial-only, cleared at restart
// - mode bit 0 drive, 1 brake or coast
// - braking bit 0 coast, 1 auto regen
// - auto regen when back voltage exceeds speed
// - timeout field forces speed zero after silence
// - gate bit enables the other config bits
// - feature config codes 75/35, write one clears
// - bit 8 enables top speed supply compensation
// - bit 7 turns brake input into logic input
// - seven bit unit address, code 7C, restored
// - send own unit address after start
// - reject trim off by over twenty percent
// - read answers two data bytes and checksum
`timescale 1ns/1ns
`include "msc_regs.vh"
module msc_top #(
    parameter        BIT_CYC  = `MSC_BIT_CYC,
    parameter [31:0] TO_A_CYC = `MSC_TO_A_CYC,
    parameter [31:0] TO_B_CYC = `MSC_TO_B_CYC,
    parameter [31:0] TO_C_CYC = `MSC_TO_C_CYC,
    parameter [13:0] FW_VER   = 14'h0001, // arbitrary value
    parameter [13:0] HW_VER   = 14'h0001  // arbitrary value
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // serial link
    input  wire        i_rx,
    output wire        o_tx,
    // flash store port
    output reg         o_flash_start,
    output reg  [4:0]  o_flash_sel,
    input  wire        i_flash_done,
    // values restored from flash at restart
    input  wire        i_nv_valid,
    input  wire [4:0]  i_nv_sel,
    input  wire [6:0]  i_nv_addr,
    input  wire [13:0] i_nv_trim,
    // controller core measurements
    input  wire [13:0] i_current_meas,
    input  wire [13:0] i_back_emf,
    input  wire [13:0] i_speed_cmd,
    input  wire        i_speed_update,
    // controller core settings
    output reg         o_pwm_halt,
    output reg  [4:0]  o_store_lock,
    output reg         o_forward_direction,
    output reg         o_operating_mode_select,
    output reg         o_braking_style,
    output reg         o_regen,
    output reg         o_speed_zero,
    output reg         o_supply_comp,
    output reg         o_brake_input_off,
    output reg         o_pulse_meas_resolution,
    output reg  [1:0]  o_baud_select,
    output reg  [6:0]  o_unit_addr,
    output reg  [13:0] o_current_trim
);
    // parser states
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_CMD   = 7'h02;
    localparam [6:0] S_D1    = 7'h04;
    localparam [6:0] S_D2    = 7'h08;
    localparam [6:0] S_CHK   = 7'h10;
    localparam [6:0] S_TX    = 7'h20;
    localparam [6:0] S_STORE = 7'h40;

    reg  [6:0]  st_reg;
    reg  [6:0]  cmd_reg;
    reg  [6:0]  d1_reg;
    reg  [6:0]  d2_reg;
    reg  [13:0] store_sel_reg;
    reg  [13:0] drive_cfg_reg;
    reg  [13:0] feat_cfg_reg;
    reg         init_reg;
    reg         boot_pend_reg;
    reg  [20:0] tx_buf_reg;
    reg  [1:0]  tx_left_reg;
    reg         tx_ld_reg;
    reg         tx_start_reg;
    reg  [7:0]  tx_data_reg;
    reg  [31:0] to_cnt_reg;
    reg  [13:0] rd_val;
    reg         rd_ok;
    reg  [31:0] to_lim;
    wire        rx_valid;
    wire [7:0]  rx_data;
    wire        tx_busy;
    wire [13:0] wr_val;
    wire [6:0]  wr_sum;
    wire [6:0]  rd_sum;
    wire [16:0] diff5;
    wire [16:0] meas;
    wire        trim_ok;
    wire        gate;

    // serial line
    msc_uart #(
        .BIT_CYC    (BIT_CYC)
    ) u_uart (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_rx       (i_rx),
        .o_tx       (o_tx),
        .o_rx_valid (rx_valid),
        .o_rx_data  (rx_data),
        .i_tx_start (tx_start_reg),
        .i_tx_data  (tx_data_reg),
        .o_tx_busy  (tx_busy)
    );

    // frame data and checksums
    assign wr_val = {d1_reg, d2_reg};
    assign wr_sum = cmd_reg + d1_reg + d2_reg;
    assign rd_sum = rd_val[13:7] + rd_val[6:0] + cmd_reg;

    // trim window: 5*error <= measurement
    assign meas    = {3'h0, i_current_meas};
    assign diff5   = (wr_val > i_current_meas) ?
                     {3'h0, wr_val - i_current_meas} * 17'd5 :
                     {3'h0, i_current_meas - wr_val} * 17'd5;
    assign trim_ok = (diff5 <= meas);

    assign gate = drive_cfg_reg[`MSC_DC_GATE];

    // read data mux
    always @* begin
        rd_val = 14'h0000;
        rd_ok  = 1'b1;
        case (cmd_reg)
            `MSC_RD_STORE_SEL: rd_val = store_sel_reg;
            `MSC_RD_DRIVE_CFG: rd_val = drive_cfg_reg;
            `MSC_RD_FEAT_CFG:  rd_val = feat_cfg_reg;
            `MSC_RD_FW_VER:    rd_val = FW_VER;
            `MSC_RD_HW_VER:    rd_val = HW_VER;
            default:           rd_ok  = 1'b0;
        endcase
    end

    // frame parser and register writes
    always @(posedge i_clk) begin
        o_flash_start <= 1'b0;
        tx_start_reg  <= 1'b0;
        if (i_srst) begin
            st_reg        <= S_IDLE;
            cmd_reg       <= 7'h00;
            d1_reg        <= 7'h00;
            d2_reg        <= 7'h00;
            store_sel_reg <= `MSC_RST_STORE_SEL;
            drive_cfg_reg <= `MSC_RST_DRIVE_CFG;
            feat_cfg_reg  <= `MSC_RST_FEAT_CFG;
            o_unit_addr   <= `MSC_RST_UNIT_ADDR;
            o_current_trim <= `MSC_RST_CUR_TRIM;
            o_store_lock  <= 5'h00;
            o_flash_sel   <= 5'h00;
            o_pwm_halt    <= 1'b0;
            init_reg      <= 1'b1;
            boot_pend_reg <= 1'b1;
            tx_buf_reg    <= 21'h000000;
            tx_left_reg   <= 2'h0;
            tx_ld_reg     <= 1'b0;
            tx_data_reg   <= 8'h00;
        end else if (init_reg) begin
            // restore stored values
            init_reg <= 1'b0;
            if (i_nv_valid) begin
                o_unit_addr    <= i_nv_addr;
                o_current_trim <= i_nv_trim;
                store_sel_reg  <= {9'h000, i_nv_sel};
                o_store_lock   <= i_nv_sel;
            end
        end else begin
            case (st_reg)
                S_IDLE: begin
                    if (boot_pend_reg && !tx_busy) begin
                        boot_pend_reg <= 1'b0;
                        tx_start_reg  <= 1'b1;
                        tx_data_reg   <= {1'b0, o_unit_addr};
                    end else if (rx_valid && rx_data[`MSC_ADDR_FLAG] &&
                                 rx_data[6:0] == o_unit_addr) begin
                        st_reg <= S_CMD;
                    end
                end
                S_CMD, S_D1, S_D2, S_CHK: begin
                    if (rx_valid && rx_data[`MSC_ADDR_FLAG]) begin
                        st_reg <= (rx_data[6:0] == o_unit_addr) ? S_CMD : S_IDLE;
                    end else if (rx_valid) begin
                        case (st_reg)
                            S_CMD: begin
                                cmd_reg <= rx_data[6:0];
                                st_reg  <= rx_data[6] ? S_D1 : S_TX;
                            end
                            S_D1: begin
                                d1_reg <= rx_data[6:0];
                                st_reg <= S_D2;
                            end
                            S_D2: begin
                                d2_reg <= rx_data[6:0];
                                st_reg <= S_CHK;
                            end
                            default: begin
                                st_reg <= S_IDLE;
                                if (rx_data[6:0] == wr_sum) begin
                                    case (cmd_reg)
                                        `MSC_WR_STORE_SEL: begin
                                            store_sel_reg <= wr_val & `MSC_SEL_MASK;
                                            o_flash_sel   <= wr_val[4:0];
                                            o_flash_start <= 1'b1;
                                            o_pwm_halt    <= 1'b1;
                                            o_store_lock  <= o_store_lock | wr_val[4:0];
                                            st_reg        <= S_STORE;
                                        end
                                        `MSC_WR_DRIVE_CFG:
                                            drive_cfg_reg <= wr_val & `MSC_DC_MASK;
                                        `MSC_WR_FEAT_CFG:
                                            feat_cfg_reg <= feat_cfg_reg &
                                                ~(wr_val & `MSC_FC_MASK);
                                        `MSC_WR_UNIT_ADDR:
                                            o_unit_addr <= d2_reg;
                                        `MSC_WR_CUR_TRIM:
                                            if (trim_ok) begin
                                                o_current_trim <= wr_val;
                                            end
                                        default: ;
                                    endcase
                                end
                            end
                        endcase
                    end
                end
                S_TX: begin
                    // load answer once, then three bytes
                    if (!tx_start_reg && !tx_busy) begin
                        if (!tx_ld_reg) begin
                            tx_ld_reg   <= rd_ok;
                            tx_buf_reg  <= {rd_val, rd_sum};
                            tx_left_reg <= 2'h3;
                            if (!rd_ok) begin
                                st_reg <= S_IDLE;
                            end
                        end else if (tx_left_reg == 2'h0) begin
                            tx_ld_reg <= 1'b0;
                            st_reg    <= S_IDLE;
                        end else begin
                            tx_start_reg <= 1'b1;
                            tx_data_reg  <= {1'b0, tx_buf_reg[20:14]};
                            tx_buf_reg   <= {tx_buf_reg[13:0], 7'h00};
                            tx_left_reg  <= tx_left_reg - 2'h1;
                        end
                    end
                end
                S_STORE: begin
                    // bytes dropped until done
                    if (i_flash_done) begin
                        o_pwm_halt <= 1'b0;
                        st_reg     <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // timeout limit
    always @* begin
        case (drive_cfg_reg[`MSC_DC_TO_HI:`MSC_DC_TO_LO])
            2'h1:    to_lim = TO_A_CYC;
            2'h2:    to_lim = TO_B_CYC;
            2'h3:    to_lim = TO_C_CYC;
            default: to_lim = 32'h00000000;
        endcase
    end

    // speed update watchdog
    always @(posedge i_clk) begin
        if (i_srst) begin
            to_cnt_reg   <= 32'h00000000;
            o_speed_zero <= 1'b0;
        end else if (i_speed_update || !gate || to_lim == 32'h00000000) begin
            to_cnt_reg   <= 32'h00000000;
            o_speed_zero <= 1'b0;
        end else if (to_cnt_reg >= to_lim - 32'h00000001) begin
            o_speed_zero <= 1'b1;
        end else begin
            to_cnt_reg <= to_cnt_reg + 32'h00000001;
        end
    end

    // core settings, drive bits gated
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_forward_direction     <= 1'b0;
            o_operating_mode_select <= 1'b0;
            o_braking_style         <= 1'b0;
            o_regen                 <= 1'b0;
            o_supply_comp           <= 1'b0;
            o_brake_input_off       <= 1'b0;
            o_pulse_meas_resolution <= 1'b0;
            o_baud_select           <= `MSC_BAUD_CODE_19200;
        end else begin
            o_forward_direction     <= gate & drive_cfg_reg[`MSC_DC_FWD];
            o_operating_mode_select <= gate & drive_cfg_reg[`MSC_DC_MODE];
            o_braking_style         <= gate & drive_cfg_reg[`MSC_DC_BRAKE];
            o_regen                 <= gate & drive_cfg_reg[`MSC_DC_BRAKE] &
                                       (i_back_emf > i_speed_cmd);
            o_supply_comp           <= feat_cfg_reg[`MSC_FC_SUPPLY];
            o_brake_input_off       <= feat_cfg_reg[`MSC_FC_PIN_OFF];
            o_pulse_meas_resolution <= feat_cfg_reg[`MSC_FC_PULSE_RES];
            o_baud_select           <= feat_cfg_reg[`MSC_FC_BAUD_HI:`MSC_FC_BAUD_LO];
        end
    end
endmodule

// ---- hw/msc_uart.v ----
// 8N1 uart receiver and transmitter
`timescale 1ns/1ns
module msc_uart #(
    parameter BIT_CYC = 6510
) (
    // clock and reset
    input  wire       i_clk,
    input  wire       i_srst,
    // serial pins
    input  wire       i_rx,
    output reg        o_tx,
    // received byte
    output reg        o_rx_valid,
    output reg  [7:0] o_rx_data,
    // byte to send
    input  wire       i_tx_start,
    input  wire [7:0] i_tx_data,
    output reg        o_tx_busy
);
    localparam [15:0] FULL = BIT_CYC - 1;
    localparam [15:0] HALF = BIT_CYC / 2;

    reg        rx_act_reg;
    reg [15:0] rx_cnt_reg;
    reg [3:0]  rx_bit_reg;
    reg [7:0]  rx_sh_reg;
    reg [15:0] tx_cnt_reg;
    reg [3:0]  tx_bit_reg;
    reg [9:0]  tx_sh_reg;

    // receiver: sample at bit centres
    always @(posedge i_clk) begin
        o_rx_valid <= 1'b0;
        if (i_srst) begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h00;
            o_rx_data  <= 8'h00;
        end else if (!rx_act_reg) begin
            if (!i_rx) begin
                rx_act_reg <= 1'b1;
                rx_cnt_reg <= HALF;
                rx_bit_reg <= 4'h0;
            end
        end else if (rx_cnt_reg != 16'h0000) begin
            rx_cnt_reg <= rx_cnt_reg - 16'h0001;
        end else begin
            rx_cnt_reg <= FULL;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && i_rx) begin
                rx_act_reg <= 1'b0; // glitch, not a start bit
            end else if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h8) begin
                rx_sh_reg <= {i_rx, rx_sh_reg[7:1]};
            end else if (rx_bit_reg == 4'h9) begin
                rx_act_reg <= 1'b0;
                if (i_rx) begin
                    o_rx_valid <= 1'b1; // framing error drops the byte
                    o_rx_data  <= rx_sh_reg;
                end
            end
        end
    end

    // transmitter, lsb first
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_tx       <= 1'b1;
            o_tx_busy  <= 1'b0;
            tx_cnt_reg <= 16'h0000;
            tx_bit_reg <= 4'h0;
            tx_sh_reg  <= 10'h3FF;
        end else if (!o_tx_busy) begin
            if (i_tx_start) begin
                o_tx_busy  <= 1'b1;
                tx_sh_reg  <= {1'b1, i_tx_data, 1'b0};
                tx_cnt_reg <= 16'h0000;
                tx_bit_reg <= 4'h0;
            end
        end else if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        end else if (tx_bit_reg == 4'hA) begin
            o_tx_busy <= 1'b0;
        end else begin
            o_tx       <= tx_sh_reg[0];
            tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
            tx_cnt_reg <= FULL;
            tx_bit_reg <= tx_bit_reg + 4'h1;
        end
    end
endmodule

// ---- sim/msc_host.sv ----
// host model: byte sender and byte catcher
`timescale 1ns/1ns
module msc_host #(
    parameter BIT_CYC = 16
) (
    input  wire i_clk,
    output reg  o_line,
    input  wire i_tx
);
    logic [7:0] q[$];
    logic [7:0] rx_b;
    integer     k;

    initial o_line = 1'b1;

    // send one byte, lsb first
    task send(input [7:0] b);
        integer i;
        @(posedge i_clk);
        #1 o_line = 1'b0;
        for (i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge i_clk);
            #1 o_line = (i == 8) ? 1'b1 : b[i];
        end
        repeat (BIT_CYC) @(posedge i_clk);
    endtask

    // catch device bytes, drop bad stop bits
    always begin
        @(negedge i_tx);
        repeat (BIT_CYC / 2) @(posedge i_clk);
        if (i_tx === 1'b0) begin
            for (k = 0; k < 8; k++) begin
                repeat (BIT_CYC) @(posedge i_clk);
                rx_b[k] = i_tx;
            end
            repeat (BIT_CYC) @(posedge i_clk);
            if (i_tx === 1'b1) q.push_back(rx_b);
        end
    end
endmodule

// ---- sim/msc_top_props.sv ----
// port-level assertions for the serial command interpreter
`timescale 1ns/1ns
module msc_top_props #(
    parameter [31:0] TO_A_CYC = 32'd20
) (
    input wire        i_clk,
    input wire        i_srst,
    input wire        i_flash_done,
    input wire [13:0] i_back_emf,
    input wire [13:0] i_speed_cmd,
    input wire        i_speed_update,
    input wire        o_flash_start,
    input wire [4:0]  o_flash_sel,
    input wire        o_pwm_halt,
    input wire [4:0]  o_store_lock,
    input wire        o_operating_mode_select,
    input wire        o_braking_style,
    input wire        o_regen,
    input wire        o_speed_zero,
    input wire        o_supply_comp,
    input wire        o_brake_input_off,
    input wire [1:0]  o_baud_select
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    logic [31:0] quiet_reg;

    // cycles since last speed update
    always @(posedge i_clk) begin
        if (i_srst || i_speed_update) quiet_reg <= 32'h0;
        else if (quiet_reg != 32'hFFFFFFFF) quiet_reg <= quiet_reg + 32'h1;
    end

    a_flash_one_pulse: assert property (o_flash_start |=> !o_flash_start)
        else $error("flash start longer than one cycle");
    a_store_halts_pwm: assert property (o_flash_start |-> ##[0:1] o_pwm_halt)
        else $error("pwm not halted during store");
    a_halt_until_done: assert property ($fell(o_pwm_halt) |->
        ($past(i_flash_done, 1) || $past(i_flash_done, 2)))
        else $error("pwm halt dropped before store finished");
    a_halt_release: assert property (o_pwm_halt && i_flash_done |-> ##[1:2] !o_pwm_halt)
        else $error("pwm halt held after store finished");
    a_store_locks: assert property (o_flash_start |->
        ##[0:1] ((o_store_lock & o_flash_sel) == o_flash_sel))
        else $error("stored items not locked");
    a_regen_cause: assert property (o_regen |->
        ($past(i_back_emf) > $past(i_speed_cmd)) || (i_back_emf > i_speed_cmd))
        else $error("regen without back voltage above speed");
    a_speed_zero_wait: assert property ($rose(o_speed_zero) |->
        quiet_reg >= TO_A_CYC - 32'd2)
        else $error("speed forced to zero too early");
    a_reset_clear: assert property ($fell(i_srst) |-> !o_operating_mode_select &&
        !o_braking_style && o_baud_select == 2'h0 && !o_speed_zero)
        else $error("config outputs not cleared by restart");
    a_feature_clear: assert property (!o_supply_comp && !o_brake_input_off)
        else $error("write one to clear feature bit seen set");

    c_store: cover property (o_flash_start);
    c_regen: cover property (o_regen);
    c_timeout: cover property ($rose(o_speed_zero));
endmodule

bind msc_top msc_top_props #(.TO_A_CYC(TO_A_CYC)) u_props (.*);

// ---- sim/tb_top.sv ----
// self-checking bench for the serial command interpreter
`timescale 1ns/1ns
module tb_top;
    localparam BC = 16;
    logic        i_clk, i_srst, i_flash_done, i_nv_valid, i_speed_update;
    logic [4:0]  i_nv_sel;
    logic [6:0]  i_nv_addr;
    logic [13:0] i_nv_trim, i_current_meas, i_back_emf, i_speed_cmd;
    wire         o_tx, rx_line, o_flash_start, o_pwm_halt, o_forward_direction;
    wire         o_operating_mode_select, o_braking_style, o_regen, o_speed_zero;
    wire         o_supply_comp, o_brake_input_off, o_pulse_meas_resolution;
    wire [4:0]   o_flash_sel, o_store_lock;
    wire [1:0]   o_baud_select;
    wire [6:0]   o_unit_addr;
    wire [13:0]  o_current_trim;
    integer      n_mismatch, compares, fl_cnt, n_start, k;

    msc_top #(.BIT_CYC(BC), .TO_A_CYC(32'd20), .TO_B_CYC(32'd40), .TO_C_CYC(32'd80)) dut (
        .i_rx(rx_line), .*);
    msc_host #(.BIT_CYC(BC)) host (.i_clk(i_clk), .o_line(rx_line), .i_tx(o_tx));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // flash model: done 30 cycles after start
    always @(posedge i_clk) begin
        i_flash_done <= (fl_cnt == 1);
        if (o_flash_start === 1'b1) begin
            fl_cnt <= 30;
            n_start <= n_start + 1;
        end else if (fl_cnt > 0) fl_cnt <= fl_cnt - 1;
    end

    task complete_run;
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input string nm, input [15:0] exp, input [15:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task get(output [7:0] b);
        integer n;
        n = 0;
        while (host.q.size() == 0 && n < 50 * BC) begin
            @(posedge i_clk);
            n++;
        end
        if (host.q.size() == 0) begin
            n_mismatch++;
            $display("Error tx byte expected 1 seen 0");
            complete_run;
        end else b = host.q.pop_front();
    endtask

    // write frame, bad corrupts the check byte
    task wr(input [6:0] a, input [6:0] c, input [13:0] d, input [6:0] bad);
        host.send({1'b1, a});
        host.send({1'b0, c});
        host.send({1'b0, d[13:7]});
        host.send({1'b0, d[6:0]});
        host.send({1'b0, 7'(c + d[13:7] + d[6:0] + bad)});
        repeat (4) @(posedge i_clk);
    endtask

    task rd(input [6:0] a, input [6:0] c, input [13:0] e);
        logic [7:0] b1, b2, b3;
        host.send({1'b1, a});
        host.send({1'b0, c});
        get(b1);
        get(b2);
        get(b3);
        chk("read data", {2'h0, e}, {2'h0, b1[6:0], b2[6:0]});
        chk("read check", {9'h0, 7'(e[13:7] + e[6:0] + c)}, {8'h0, b3});
    endtask

    task t_boot(input nv, input [4:0] s, input [6:0] a, input [13:0] t);
        logic [7:0] b;
        i_nv_valid = nv;
        i_nv_sel = s;
        i_nv_addr = a;
        i_nv_trim = t;
        i_srst = 1'b1;
        repeat (6) @(posedge i_clk);
        #1 i_srst = 1'b0;
        get(b);
        chk("boot address", {9'h0, a}, {8'h0, b});
        chk("lock", {11'h0, s}, {11'h0, o_store_lock});
        chk("unit address", {9'h0, a}, {9'h0, o_unit_addr});
        chk("trim", {2'h0, t}, {2'h0, o_current_trim});
        chk("mode", 16'h0, {15'h0, o_operating_mode_select});
        $display("test boot done");
    endtask

    task t_drive;
        wr(7'h00, 7'h74, 14'h0019, 7'h00);
        chk("mode", 16'h1, {15'h0, o_operating_mode_select});
        chk("brake style", 16'h1, {15'h0, o_braking_style});
        chk("forward", 16'h0, {15'h0, o_forward_direction});
        chk("regen", 16'h1, {15'h0, o_regen});
        #1 i_back_emf = 14'h0032;
        repeat (3) @(posedge i_clk);
        chk("regen low", 16'h0, {15'h0, o_regen});
        rd(7'h00, 7'h34, 14'h0019);
        wr(7'h00, 7'h74, 14'h0218, 7'h00);
        chk("gated mode", 16'h0, {15'h0, o_operating_mode_select});
        chk("gated forward", 16'h0, {15'h0, o_forward_direction});
        wr(7'h00, 7'h74, 14'h0201, 7'h00);
        chk("forward", 16'h1, {15'h0, o_forward_direction});
        $display("test drive done");
    endtask

    task t_timeout;
        integer to;
        for (k = 1; k < 4; k++) begin
            to = 10 << k;
            wr(7'h00, 7'h74, 14'(k * 2 + 1), 7'h00);
            @(posedge i_clk);
            #1 i_speed_update = 1'b1;
            @(posedge i_clk);
            #1 i_speed_update = 1'b0;
            repeat (to - 3) @(posedge i_clk);
            chk("speed zero early", 16'h0, {15'h0, o_speed_zero});
            repeat (6) @(posedge i_clk);
            chk("speed zero", 16'h1, {15'h0, o_speed_zero});
        end
        wr(7'h00, 7'h74, 14'h0001, 7'h00);
        chk("speed zero off", 16'h0, {15'h0, o_speed_zero});
        $display("test timeout done");
    endtask

    task t_refuse;
        wr(7'h00, 7'h74, 14'h0019, 7'h01);
        chk("bad check", 16'h0, {15'h0, o_operating_mode_select});
        wr(7'h01, 7'h74, 14'h0019, 7'h00);
        chk("other unit", 16'h0, {15'h0, o_operating_mode_select});
        host.send(8'h80);
        host.send(8'h74);
        host.send(8'h00);
        wr(7'h00, 7'h74, 14'h0019, 7'h00);
        chk("restart frame", 16'h1, {15'h0, o_operating_mode_select});
        $display("test refuse done");
    endtask

    task t_feature;
        wr(7'h00, 7'h75, 14'h01C6, 7'h00);
        rd(7'h00, 7'h35, 14'h0000);
        chk("supply comp", 16'h0, {15'h0, o_supply_comp});
        chk("brake input off", 16'h0, {15'h0, o_brake_input_off});
        chk("baud", 16'h0, {14'h0, o_baud_select});
        $display("test feature done");
    endtask

    task t_trim;
        #1 i_current_meas = 14'd200;
        wr(7'h00, 7'h7D, 14'd241, 7'h00);
        chk("trim high", 16'h0, {2'h0, o_current_trim});
        wr(7'h00, 7'h7D, 14'd160, 7'h00);
        chk("trim edge", 16'd160, {2'h0, o_current_trim});
        $display("test trim done");
    endtask

    task t_store;
        wr(7'h00, 7'h72, 14'h001F, 7'h00);
        chk("store starts", 16'h1, n_start[15:0]);
        chk("halt", 16'h1, {15'h0, o_pwm_halt});
        chk("select", 16'h1F, {11'h0, o_flash_sel});
        chk("lock", 16'h1F, {11'h0, o_store_lock});
        repeat (40) @(posedge i_clk);
        chk("halt end", 16'h0, {15'h0, o_pwm_halt});
        rd(7'h00, 7'h33, 14'h001F);
        $display("test store done");
    endtask

    task t_addr;
        wr(7'h00, 7'h7C, 14'h0005, 7'h00);
        chk("unit address", 16'h5, {9'h0, o_unit_addr});
        rd(7'h05, 7'h34, 14'h0019);
        $display("test address done");
    endtask

    initial begin
        n_mismatch = 0;
        compares = 0;
        fl_cnt = 0;
        n_start = 0;
        i_srst = 1'b1;
        i_flash_done = 1'b0;
        i_speed_update = 1'b0;
        i_current_meas = 14'd100;
        i_back_emf = 14'd200;
        i_speed_cmd = 14'd100;
        t_boot(1'b0, 5'h00, 7'h00, 14'h0000);
        t_drive;
        t_timeout;
        t_refuse;
        t_feature;
        t_trim;
        t_store;
        t_addr;
        t_boot(1'b1, 5'h03, 7'h12, 14'h0055);
        complete_run;
    end
endmodule
